//--- hw/ccs_pkg.sv
// Constants for the comparator control and status block
// What this block does
// [R1] Invert bit flips the comparator output
// [R2] Output enable drives the output pin
// [R3] Capture enable routes output to capture
// [R4] Capture interrupt needs timer capture enable
// [R5] Edge select picks rising or falling
// [R6] Capture disabled means no capture connection
// [R7] Three-bit hysteresis select encoding
// [R8] Hardware sets flag on selected event
// [R9] Vector acknowledge clears flag when enabled
// [R10] Write one clears flag, zero keeps
// [R11] Flags serve as converter triggers
// [R12] Status bits show live comparator outputs
// [R13] Disable bit turns input buffer off
// [R14] Disabled pin reads back as zero
// [R15] Software disables unused analog input buffers
// [R16] Sensitivity: toggle, reserved, falling, rising
// [R17] Comparator runs only while enabled
// [R18] Interrupt request needs interrupt enable
// [R19] Reserved bits read zero, ignore writes (CTRL3 is stored with all eight bits writable, so its bit 3 is kept)
package ccs_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL1_OFF   = 8'h00;
  localparam logic [7:0] CTRL2_OFF   = 8'h04;
  localparam logic [7:0] CTRL3_OFF   = 8'h08;
  localparam logic [7:0] ECON1_OFF   = 8'h0C;
  localparam logic [7:0] ECON2_OFF   = 8'h10;
  localparam logic [7:0] ECON3_OFF   = 8'h14;
  localparam logic [7:0] STATUS_OFF  = 8'h18;
  localparam logic [7:0] DIS0_OFF    = 8'h1C;
  localparam logic [7:0] DIS1_OFF    = 8'h20;
  localparam logic [7:0] TIMER_OFF   = 8'h24;
  localparam logic [7:0] PINS_OFF    = 8'h28;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_IE_BIT    = 6;
  localparam int CTRL_IS_HI     = 5;
  localparam int CTRL_IS_LO     = 4;
  localparam int ECON_OI_BIT    = 5;
  localparam int ECON_OE_BIT    = 4;
  localparam int ECON_ICE_BIT   = 3;
  localparam int ECON_HYS_HI    = 2;
  localparam int FLAG_LSB       = 5;
  localparam int LIVE_LSB       = 1;
  localparam int TIM_ICIE_BIT   = 0;
  localparam int TIM_ICES_BIT   = 1;
  // ----------------------------------------
  // Writable masks and reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_MASK   = 8'hF7;
  localparam logic [7:0] CTRL3_MASK  = 8'hFF;
  localparam logic [7:0] ECON_MASK   = 8'h3F;
  localparam logic [7:0] DIS1_MASK   = 8'h09;
  localparam logic [7:0] TIMER_MASK  = 8'h03;
  localparam logic [7:0] REG_RESET   = 8'h00;
  // ----------------------------------------
  // Sensitivity, hysteresis and response encodings
  // ----------------------------------------
  localparam logic [1:0] SENS_TOGGLE = 2'h0;
  localparam logic [1:0] SENS_RSVD   = 2'h1;
  localparam logic [1:0] SENS_FALL   = 2'h2;
  localparam logic [1:0] SENS_RISE   = 2'h3;
  localparam logic [2:0] HYS_RSVD    = 3'h4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ccs_pkg

//--- hw/ccs_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module ccs_sync3 #(
  parameter int W = 3
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout   <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
        begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : ccs_sync3

//--- hw/ccs_top.sv
// Comparator control, status, capture routing and input-disable logic with AXI4-Lite
`timescale 1ns/1ps
module ccs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog side
  input  wire logic [2:0]  cmp_raw_out,
  input  wire logic [2:0]  irq_vector_ack,
  input  wire logic [9:0]  analog_pin_in,
  output logic [2:0]       cmp_enable,
  output logic [8:0]       cmp_hysteresis_select,
  output logic [2:0]       cmp_output_pin,
  output logic [2:0]       cmp_output_pin_oe,
  output logic [2:0]       cmp_irq_req,
  output logic [2:0]       conv_trigger,
  output logic [9:0]       cmp_input_buffer_off,
  // Timer capture front end
  output logic             timer_capture_in,
  output logic             timer_capture_route,
  output logic             timer_capture_edge_select,
  output logic             timer_capture_irq_enable
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctrl_reg [3];
  logic [7:0] econ_reg [3];
  logic [2:0] flag_reg;
  logic [7:0] dis0_reg;
  logic [7:0] dis1_reg;
  logic [7:0] timer_irq_mask_reg;
  logic [2:0] prev_reg;
  logic [2:0] cmp_sync;
  logic [9:0] pin_sync;
  logic [2:0] eff_out;
  logic [2:0] event_hit;
  logic [2:0] w1c;

  // Raw comparator and pin levels cross from the analog domain
  ccs_sync3 #(.W(3)) u_cmp_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (cmp_raw_out),
    .dout    (cmp_sync)
  );

  ccs_sync3 #(.W(10)) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (analog_pin_in),
    .dout    (pin_sync)
  );

  // ----------------------------------------
  // Output conditioning
  // ----------------------------------------
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      // Disabled comparator holds low; only the drop on disabling a high output can raise an event
      eff_out[i] = ctrl_reg[i][ccs_pkg::CTRL_EN_BIT]                    // R17
                   & (cmp_sync[i] ^ econ_reg[i][ccs_pkg::ECON_OI_BIT]); // R1
    end
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      case (ctrl_reg[i][ccs_pkg::CTRL_IS_HI:ccs_pkg::CTRL_IS_LO])       // R16
        ccs_pkg::SENS_TOGGLE: event_hit[i] = eff_out[i] ^ prev_reg[i];
        ccs_pkg::SENS_FALL:   event_hit[i] = prev_reg[i] & ~eff_out[i];
        ccs_pkg::SENS_RISE:   event_hit[i] = ~prev_reg[i] & eff_out[i];
        default:              event_hit[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_reg <= 3'h0;
    end
    else
    begin
      prev_reg <= eff_out;
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  // Set wins over a same-cycle software or vector clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_reg <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (event_hit[i])
        begin
          flag_reg[i] <= 1'b1;                                           // R8
        end
        else if (w1c[i])
        begin
          flag_reg[i] <= 1'b0;                                           // R10
        end
        else if (irq_vector_ack[i] && ctrl_reg[i][ccs_pkg::CTRL_IE_BIT])
        begin
          flag_reg[i] <= 1'b0;                                           // R9
        end
      end
    end
  end

  // ----------------------------------------
  // Pin and downstream outputs
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_enable                <= 3'h0;
      cmp_hysteresis_select     <= 9'h000;
      cmp_output_pin            <= 3'h0;
      cmp_output_pin_oe         <= 3'h0;
      cmp_irq_req               <= 3'h0;
      conv_trigger              <= 3'h0;
      cmp_input_buffer_off      <= 10'h000;
      timer_capture_in          <= 1'b0;
      timer_capture_route       <= 1'b0;
      timer_capture_edge_select <= 1'b0;
      timer_capture_irq_enable  <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        cmp_enable[i]           <= ctrl_reg[i][ccs_pkg::CTRL_EN_BIT];    // R17
        cmp_hysteresis_select[3*i +: 3] <= econ_reg[i][ccs_pkg::ECON_HYS_HI:0]; // R7
        cmp_output_pin[i]       <= eff_out[i] & econ_reg[i][ccs_pkg::ECON_OE_BIT];
        cmp_output_pin_oe[i]    <= econ_reg[i][ccs_pkg::ECON_OE_BIT];   // R2
        cmp_irq_req[i]          <= flag_reg[i] & ctrl_reg[i][ccs_pkg::CTRL_IE_BIT]; // R18
      end
      conv_trigger              <= flag_reg;                             // R11
      cmp_input_buffer_off      <= {dis1_reg[3], dis1_reg[0], dis0_reg}; // R13
      // Comparator 1 feeds capture; gated low when route is off
      timer_capture_in          <= eff_out[0] & econ_reg[0][ccs_pkg::ECON_ICE_BIT]; // R3 R6
      timer_capture_route       <= econ_reg[0][ccs_pkg::ECON_ICE_BIT];  // R3
      timer_capture_edge_select <= timer_irq_mask_reg[ccs_pkg::TIM_ICES_BIT]; // R5
      timer_capture_irq_enable  <= timer_irq_mask_reg[ccs_pkg::TIM_ICIE_BIT]; // R4
    end
  end

  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic        do_write;
  logic [7:0]  wb;

  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign wb       = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
  assign w1c      = (do_write && aw_addr_reg == ccs_pkg::STATUS_OFF)
                    ? wb[ccs_pkg::FLAG_LSB +: 3] : 3'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ccs_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > ccs_pkg::TIMER_OFF || aw_addr_reg[1:0] != 2'h0)
                        ? ccs_pkg::RESP_SLVERR : ccs_pkg::RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage; reserved bits masked off on write, except in CTRL3, which keeps all eight bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        ctrl_reg[i] <= ccs_pkg::REG_RESET;
        econ_reg[i] <= ccs_pkg::REG_RESET;
      end
      dis0_reg           <= ccs_pkg::REG_RESET;
      dis1_reg           <= ccs_pkg::REG_RESET;
      timer_irq_mask_reg <= ccs_pkg::REG_RESET;
    end
    else if (do_write && w_strb_reg[0])
    begin
      if (aw_addr_reg == ccs_pkg::CTRL1_OFF)
        ctrl_reg[0] <= w_data_reg[7:0] & ccs_pkg::CTRL_MASK;            // R19
      else if (aw_addr_reg == ccs_pkg::CTRL2_OFF)
        ctrl_reg[1] <= w_data_reg[7:0] & ccs_pkg::CTRL_MASK;
      else if (aw_addr_reg == ccs_pkg::CTRL3_OFF)
        ctrl_reg[2] <= w_data_reg[7:0] & ccs_pkg::CTRL3_MASK;
      else if (aw_addr_reg == ccs_pkg::ECON1_OFF)
        econ_reg[0] <= w_data_reg[7:0] & ccs_pkg::ECON_MASK;            // R19
      else if (aw_addr_reg == ccs_pkg::ECON2_OFF)
        econ_reg[1] <= w_data_reg[7:0] & ccs_pkg::ECON_MASK & ~8'h08;
      else if (aw_addr_reg == ccs_pkg::ECON3_OFF)
        econ_reg[2] <= w_data_reg[7:0] & ccs_pkg::ECON_MASK & ~8'h08;
      else if (aw_addr_reg == ccs_pkg::DIS0_OFF)
        dis0_reg <= w_data_reg[7:0];
      else if (aw_addr_reg == ccs_pkg::DIS1_OFF)
        dis1_reg <= w_data_reg[7:0] & ccs_pkg::DIS1_MASK;
      else if (aw_addr_reg == ccs_pkg::TIMER_OFF)
        timer_irq_mask_reg <= w_data_reg[7:0] & ccs_pkg::TIMER_MASK;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  logic [7:0] rd_byte;
  logic       rd_bad;
  logic [9:0] pin_read;

  assign pin_read = pin_sync & ~{dis1_reg[3], dis1_reg[0], dis0_reg};   // R14

  always_comb
  begin
    rd_byte = 8'h00;
    rd_bad  = 1'b0;
    if (s_axi_araddr[1:0] != 2'h0)
      rd_bad = 1'b1;
    else if (s_axi_araddr == ccs_pkg::CTRL1_OFF)
      rd_byte = ctrl_reg[0];
    else if (s_axi_araddr == ccs_pkg::CTRL2_OFF)
      rd_byte = ctrl_reg[1];
    else if (s_axi_araddr == ccs_pkg::CTRL3_OFF)
      rd_byte = ctrl_reg[2];
    else if (s_axi_araddr == ccs_pkg::ECON1_OFF)
      rd_byte = econ_reg[0];
    else if (s_axi_araddr == ccs_pkg::ECON2_OFF)
      rd_byte = econ_reg[1];
    else if (s_axi_araddr == ccs_pkg::ECON3_OFF)
      rd_byte = econ_reg[2];
    else if (s_axi_araddr == ccs_pkg::STATUS_OFF)
      rd_byte = {flag_reg, 1'b0, eff_out, 1'b0};                        // R12 R19
    else if (s_axi_araddr == ccs_pkg::DIS0_OFF)
      rd_byte = dis0_reg;
    else if (s_axi_araddr == ccs_pkg::DIS1_OFF)
      rd_byte = dis1_reg;
    else if (s_axi_araddr == ccs_pkg::TIMER_OFF)
      rd_byte = timer_irq_mask_reg;
    else if (s_axi_araddr == ccs_pkg::PINS_OFF)
      rd_byte = pin_read[7:0];
    else
      rd_bad = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ccs_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= (s_axi_araddr == ccs_pkg::PINS_OFF)
                        ? {22'h0, pin_read} : {24'h000000, rd_byte};
        s_axi_rresp  <= rd_bad ? ccs_pkg::RESP_SLVERR : ccs_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : ccs_top

//--- bench/ccs_properties.sv
// Port assertions for the comparator control block
`timescale 1ns/1ps
module ccs_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [2:0]  cmp_enable,
  input wire logic [2:0]  cmp_output_pin,
  input wire logic [2:0]  cmp_output_pin_oe,
  input wire logic [2:0]  cmp_irq_req,
  input wire logic [2:0]  conv_trigger,
  input wire logic        timer_capture_in,
  input wire logic        timer_capture_route
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_pin_oe_gate: assert property ((cmp_output_pin & ~cmp_output_pin_oe) == 3'h0)
    else $error("output pin driven while its enable is low");
  a_route_off: assert property (!timer_capture_route |-> !timer_capture_in)
    else $error("capture input active with routing off");
  a_irq_needs_flag: assert property ((cmp_irq_req & ~conv_trigger) == 3'h0)
    else $error("interrupt request without its flag");
  a_reset_clear: assert property ($rose(aresetn) |-> cmp_enable == 3'h0 && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
endmodule : ccs_properties

//--- bench/ccs_analog_model.sv
// Comparator output and timer capture stand-in
`timescale 1ns/1ps
module ccs_analog_model (
  input  wire logic       aclk,
  input  wire logic [2:0] cmp_level,
  input  wire logic [9:0] pin_level,
  input  wire logic       timer_capture_in,
  input  wire logic       timer_capture_edge_select,
  input  wire logic       timer_capture_irq_enable,
  output logic      [2:0] cmp_raw_out,
  output logic      [9:0] analog_pin_in,
  output int              capture_count,
  output int              capture_irq_count
);
  logic prev_in = 1'b0;
  assign cmp_raw_out   = cmp_level;
  assign analog_pin_in = pin_level;
  initial
  begin
    capture_count     = 0;
    capture_irq_count = 0;
  end
  // Capture front end counts only the selected edge
  always @(posedge aclk)
  begin
    prev_in <= timer_capture_in;
    if (timer_capture_in != prev_in && timer_capture_in == timer_capture_edge_select)
    begin
      capture_count <= capture_count + 1;
      if (timer_capture_irq_enable)
        capture_irq_count <= capture_irq_count + 1;
    end
  end
endmodule : ccs_analog_model

//--- bench/tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic timer_capture_in, timer_capture_route, timer_capture_edge_select;
  logic timer_capture_irq_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, v0, v1;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  cmp_raw_out, irq_vector_ack, cmp_enable, cmp_output_pin, cmp_output_pin_oe;
  logic [2:0]  cmp_irq_req, conv_trigger, cmp_level;
  logic [8:0]  cmp_hysteresis_select;
  logic [9:0]  analog_pin_in, cmp_input_buffer_off, pin_level;
  int          capture_count, capture_irq_count, c0, c1, checked, err_count;
  ccs_top ccs_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_raw_out, .irq_vector_ack, .analog_pin_in, .cmp_enable,
    .cmp_hysteresis_select, .cmp_output_pin, .cmp_output_pin_oe, .cmp_irq_req, .conv_trigger,
    .cmp_input_buffer_off, .timer_capture_in, .timer_capture_route,
    .timer_capture_edge_select, .timer_capture_irq_enable);
  ccs_analog_model ccs_analog_model_i (.aclk, .cmp_level, .pin_level, .timer_capture_in,
    .timer_capture_edge_select, .timer_capture_irq_enable, .cmp_raw_out, .analog_pin_in,
    .capture_count, .capture_irq_count);
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    // A lost write answer ends the run as a mismatch
    if (!s_axi_bvalid)
    begin
      err_count++;
      give_verdict();
    end
    chk("bresp", r, s_axi_bresp);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    v = s_axi_rdata;
    if (!s_axi_rvalid)
    begin
      err_count++;
      give_verdict();
    end
  endtask : rd
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      ccs_pkg::CTRL3_OFF: return ccs_pkg::CTRL3_MASK;
      ccs_pkg::ECON1_OFF: return ccs_pkg::ECON_MASK;
      // Capture routing exists for comparator 1 only
      ccs_pkg::ECON2_OFF, ccs_pkg::ECON3_OFF:
        return ccs_pkg::ECON_MASK & ~(8'h01 << ccs_pkg::ECON_ICE_BIT);
      ccs_pkg::DIS0_OFF: return 8'hFF;
      ccs_pkg::DIS1_OFF: return ccs_pkg::DIS1_MASK;
      ccs_pkg::TIMER_OFF: return ccs_pkg::TIMER_MASK;
      default: return ccs_pkg::CTRL_MASK;
    endcase
  endfunction : msk
  function automatic logic flag_exp(input int s, input int e);
    return s == 0 || (s == 3 && e == 1) || (s == 2 && e == 0);
  endfunction : flag_exp
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmp_level, pin_level, irq_vector_ack} = '0;
    s_axi_wstrb = 4'hF;
    void'($urandom(49219));
    tick(3);
    aresetn <= 1'b1;
    for (int a = 0; a <= 'h28; a += 4)
    begin
      rd(8'(a), d);
      chk("reset value", 32'h0, d);
    end
    for (int a = 0; a <= 'h24; a += 4)
    begin
      v0 = (a == 'h18) ? 8'h00 : 8'($urandom);
      wr(8'(a), v0, ccs_pkg::RESP_OKAY);
      rd(8'(a), d);
      chk("register", {24'h0, v0 & msk(8'(a))}, d);
      wr(8'(a), 8'h00, ccs_pkg::RESP_OKAY);
    end
    wr(8'h30, 8'hFF, ccs_pkg::RESP_SLVERR);
    rd(8'h30, d);
    chk("unmapped", 32'h0, d);
    chk("rresp", ccs_pkg::RESP_SLVERR, s_axi_rresp);
    wr(8'h02, 8'hFF, ccs_pkg::RESP_SLVERR);
    rd(ccs_pkg::CTRL1_OFF, d);
    chk("unaligned", 32'h0, d);
    chk("rresp ok", ccs_pkg::RESP_OKAY, s_axi_rresp);
    $display("test registers done");
    wr(ccs_pkg::CTRL1_OFF, 8'h80, ccs_pkg::RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      wr(ccs_pkg::ECON1_OFF, k[1] ? 8'h30 : 8'h10, ccs_pkg::RESP_OKAY);
      cmp_level[0] <= k[0];
      tick(8);
      rd(ccs_pkg::STATUS_OFF, d);
      chk("live", {30'h0, k[0] ^ k[1], 1'b0}, d & 32'h0E);
      chk("pin", {31'h0, k[0] ^ k[1]}, cmp_output_pin[0]);
      chk("pin oe", 32'h1, cmp_output_pin_oe);
      chk("enable", 32'h1, cmp_enable);
    end
    wr(ccs_pkg::CTRL1_OFF, 8'h00, ccs_pkg::RESP_OKAY);
    tick(4);
    rd(ccs_pkg::STATUS_OFF, d);
    chk("disabled", 32'h0, d & 32'h0E);
    cmp_level[0] <= 1'b0;
    $display("test live output done");
    for (int s = 0; s < 4; s++)
    begin
      wr(ccs_pkg::CTRL2_OFF, 8'h80 | 8'(s << 4), ccs_pkg::RESP_OKAY);
      tick(8);
      wr(ccs_pkg::STATUS_OFF, 8'hE0, ccs_pkg::RESP_OKAY);
      for (int e = 1; e >= 0; e--)
      begin
        cmp_level[1] <= e[0];
        tick(8);
        chk("trigger", {31'h0, flag_exp(s, e)}, conv_trigger[1]);
        wr(ccs_pkg::STATUS_OFF, 8'h00, ccs_pkg::RESP_OKAY);
        rd(ccs_pkg::STATUS_OFF, d);
        chk("flag", {25'h0, flag_exp(s, e), 6'h0}, d & 32'h40);
        wr(ccs_pkg::STATUS_OFF, 8'h40, ccs_pkg::RESP_OKAY);
        rd(ccs_pkg::STATUS_OFF, d);
        chk("flag clear", 32'h0, d & 32'h40);
      end
    end
    $display("test sensitivity done");
    for (int ie = 0; ie < 2; ie++)
    begin
      wr(ccs_pkg::CTRL1_OFF, ie ? 8'hC0 : 8'h80, ccs_pkg::RESP_OKAY);
      wr(ccs_pkg::STATUS_OFF, 8'hE0, ccs_pkg::RESP_OKAY);
      cmp_level[0] <= ~cmp_level[0];
      tick(8);
      chk("irq", 32'(ie), cmp_irq_req[0]);
      irq_vector_ack <= 3'h1;
      tick(1);
      irq_vector_ack <= 3'h0;
      tick(4);
      chk("vector clear", 32'(1 - ie), conv_trigger[0]);
    end
    $display("test vector done");
    wr(ccs_pkg::CTRL1_OFF, 8'h80, ccs_pkg::RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      wr(ccs_pkg::ECON1_OFF, i < 4 ? 8'h08 : 8'h00, ccs_pkg::RESP_OKAY);
      wr(ccs_pkg::TIMER_OFF, 8'(i % 4), ccs_pkg::RESP_OKAY);
      c0 = capture_count;
      c1 = capture_irq_count;
      cmp_level[0] <= 1'b1;
      tick(8);
      cmp_level[0] <= 1'b0;
      tick(8);
      chk("capture", 32'(i < 4), capture_count - c0);
      chk("capture irq", 32'(i < 4 && i % 2 == 1), capture_irq_count - c1);
    end
    for (int h = 0; h < 8; h++)
    begin
      wr(ccs_pkg::ECON3_OFF, 8'(h), ccs_pkg::RESP_OKAY);
      tick(2);
      chk("hysteresis", 32'(h), cmp_hysteresis_select[8:6]);
    end
    $display("test capture done");
    repeat (4)
    begin
      pin_level <= 10'($urandom);
      v0 = 8'($urandom);
      v1 = 8'($urandom);
      wr(ccs_pkg::DIS0_OFF, v0, ccs_pkg::RESP_OKAY);
      wr(ccs_pkg::DIS1_OFF, v1, ccs_pkg::RESP_OKAY);
      tick(8);
      rd(ccs_pkg::PINS_OFF, d);
      chk("pins", {22'h0, pin_level & ~{v1[3], v1[0], v0}}, d);
      chk("buffer off", {22'h0, v1[3], v1[0], v0}, cmp_input_buffer_off);
    end
    $display("test input disable done");
    give_verdict();
  end
endmodule : tb
bind ccs_top ccs_properties ccs_properties_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cmp_enable, .cmp_output_pin,
  .cmp_output_pin_oe, .cmp_irq_req, .conv_trigger, .timer_capture_in, .timer_capture_route);
